// ==== logic/fesq_host.sv ====
/*
  Host-side controller that drives a parallel NOR flash through its strobes
  to issue chip erase, sector erase (with one extra sector), suspend, resume
  and reset, and polls the write status bits until the operation ends.
  Assumes the flash data and ready/busy pins are asynchronous to REF_CLK;
  the board resolves the data bus and the pull-up on ready/busy.
*/
`timescale 1ns/1ps
`default_nettype none
module fesq_host
  import fesq_pkg::*;
#(
  parameter logic [ADDR_W-1:0] UNLOCK1_A = fesq_pkg::UNLOCK1_ADDR,
  parameter logic [DATA_W-1:0] UNLOCK1_D = fesq_pkg::UNLOCK1_DATA,
  parameter logic [ADDR_W-1:0] UNLOCK2_A = fesq_pkg::UNLOCK2_ADDR,
  parameter logic [DATA_W-1:0] UNLOCK2_D = fesq_pkg::UNLOCK2_DATA
) (
  input  wire logic                         REF_CLK,
  input  wire logic                         ARST_N,
  input  wire logic                         CLK_EN,
  input  wire logic                         START_CHIP,
  input  wire logic                         START_SECTOR,
  input  wire logic                         ADD_SECTOR,
  input  wire logic [fesq_pkg::ADDR_W-1:0]  SECTOR_ADDR,
  input  wire logic                         SUSPEND,
  input  wire logic                         RESUME,
  input  wire logic                         ABORT,
  output logic                              BUSY,
  output logic                              DONE,
  output logic                              FAILED,
  output logic                              SUSPENDED,
  output logic                              WINDOW_OPEN,
  output logic [fesq_pkg::ADDR_W-1:0]       FL_ADDR,
  output logic [fesq_pkg::DATA_W-1:0]       FL_DQ_O,
  output logic                              FL_DQ_OE,
  input  wire logic [fesq_pkg::DATA_W-1:0]  FL_DQ_I,
  output logic                              FL_CE_N,
  output logic                              FL_WE_N,
  output logic                              FL_OE_N,
  output logic                              FL_RESET_N,
  input  wire logic                         FL_RDY_I
);
  import fesq_pkg::*;

  typedef enum logic [6:0] {
    S_IDLE  = 7'b000_0001,
    S_CMD   = 7'b000_0010,
    S_WIN   = 7'b000_0100,
    S_POLL  = 7'b000_1000,
    S_SUSP  = 7'b001_0000,
    S_RST   = 7'b010_0000,
    S_HWRST = 7'b100_0000
  } fesq_state_e;

  typedef enum logic [2:0] {
    K_CHIP = 3'b001,
    K_SECT = 3'b010,
    K_ONE  = 3'b100
  } fesq_kind_e;

  fesq_state_e             state_q;
  fesq_kind_e              kind_q;
  logic [2:0]              idx_q;
  logic [1:0]              ph_q;
  logic [CNT_W-1:0]        win_q;
  logic [DATA_W-1:0]       cmd_d;
  logic [ADDR_W-1:0]       cmd_a;
  logic [ADDR_W-1:0]       sect_q;
  logic [DATA_W-1:0]       one_q;
  logic [DATA_W-1:0]       dq_s1_q;
  logic [DATA_W-1:0]       dq_s2_q;
  logic                    rdy_s1_q;
  logic                    rdy_s2_q;
  logic                    have_prev_q;
  logic                    prev_t1_q;
  logic                    to_seen_q;
  logic                    last_cyc;
  logic                    win_left;

  // Six-cycle erase sequence, or one single command cycle.
  always_comb begin
    cmd_a = UNLOCK1_A;
    cmd_d = UNLOCK1_D;
    unique case (idx_q)
      3'd1, 3'd4: begin
        cmd_a = UNLOCK2_A;
        cmd_d = UNLOCK2_D;
      end
      3'd2: cmd_d = CMD_SETUP;
      3'd5: begin
        cmd_a = (kind_q == K_CHIP) ? UNLOCK1_A : sect_q;
        cmd_d = (kind_q == K_CHIP) ? CMD_CHIP_ERASE : CMD_SECTOR_ERASE;
      end
      default: ;
    endcase
    if (kind_q == K_ONE) begin
      cmd_a = sect_q;
      cmd_d = one_q;
    end
  end

  assign last_cyc = (kind_q == K_ONE) || (idx_q == 3'd5);
  // Extra sectors go out only while enough of the window is left.
  assign win_left = (win_q > CNT_W'(4 * PHASE_CYC));

  // The flash pins are asynchronous, so two flops precede any use.
  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      dq_s1_q  <= '0;
      dq_s2_q  <= '0;
      rdy_s1_q <= 1'b0;
      rdy_s2_q <= 1'b0;
    end else if (CLK_EN) begin
      dq_s1_q  <= FL_DQ_I;
      dq_s2_q  <= dq_s1_q;
      rdy_s1_q <= FL_RDY_I;
      rdy_s2_q <= rdy_s1_q;
    end
  end

  always_ff @(posedge REF_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_q     <= S_IDLE;
      kind_q      <= K_SECT;
      idx_q       <= '0;
      ph_q        <= '0;
      win_q       <= '0;
      sect_q      <= '0;
      one_q       <= '0;
      have_prev_q <= 1'b0;
      prev_t1_q   <= 1'b0;
      to_seen_q   <= 1'b0;
      FL_ADDR     <= '0;
      FL_DQ_O     <= '0;
      FL_DQ_OE    <= 1'b0;
      FL_CE_N     <= 1'b1;
      FL_WE_N     <= 1'b1;
      FL_OE_N     <= 1'b1;
      FL_RESET_N  <= 1'b1;
      BUSY        <= 1'b0;
      DONE        <= 1'b0;
      FAILED      <= 1'b0;
      SUSPENDED   <= 1'b0;
      WINDOW_OPEN <= 1'b0;
    end else if (CLK_EN) begin
      DONE <= 1'b0;
      if (win_q != '0) begin
        win_q <= win_q - 1'b1;
      end
      // A hardware reset pulse wins over any phase of any operation.
      if (ABORT && state_q != S_HWRST) begin
        state_q     <= S_HWRST;
        ph_q        <= '0;
        FL_RESET_N  <= 1'b0;
        FL_CE_N     <= 1'b1;
        FL_WE_N     <= 1'b1;
        FL_OE_N     <= 1'b1;
        FL_DQ_OE    <= 1'b0;
        WINDOW_OPEN <= 1'b0;
        SUSPENDED   <= 1'b0;
      end else begin
        unique case (state_q)
          S_IDLE: begin
            FAILED <= 1'b0;
            if (START_CHIP || START_SECTOR) begin
              kind_q  <= START_CHIP ? K_CHIP : K_SECT;
              sect_q  <= SECTOR_ADDR;
              idx_q   <= '0;
              ph_q    <= '0;
              BUSY    <= 1'b1;
              state_q <= S_CMD;
            end
          end
          // Address and data go out as CE falls, a cycle ahead of WE, and are held past
          // their rise, so either edge rule in the device is satisfied.
          S_CMD: begin
            ph_q <= ph_q + 2'd1;
            unique case (ph_q)
              2'd0: begin
                FL_ADDR  <= cmd_a;
                FL_DQ_O  <= cmd_d;
                FL_DQ_OE <= 1'b1;
                FL_CE_N  <= 1'b0;
              end
              2'd1: FL_WE_N <= 1'b0;
              2'd2: begin
                FL_WE_N <= 1'b1;
                FL_CE_N <= 1'b1;
              end
              default: begin
                ph_q     <= '0;
                FL_DQ_OE <= 1'b0;
                if (!last_cyc) begin
                  idx_q <= idx_q + 3'd1;
                end else if (kind_q == K_SECT) begin
                  win_q       <= CNT_W'(LOAD_WINDOW_CYC);
                  WINDOW_OPEN <= 1'b1;
                  state_q     <= S_WIN;
                end else begin
                  have_prev_q <= 1'b0;
                  to_seen_q   <= 1'b0;
                  state_q     <= (one_q == CMD_RESET) ? S_IDLE : S_POLL;
                  BUSY        <= (one_q != CMD_RESET);
                end
              end
            endcase
          end
          // Only 30H or B0H may follow while the load window is open.
          S_WIN: begin
            if (SUSPEND) begin
              kind_q  <= K_ONE;
              one_q   <= CMD_SUSPEND;
              state_q <= S_CMD;
            end else if (ADD_SECTOR && win_left) begin
              kind_q  <= K_ONE;
              sect_q  <= SECTOR_ADDR;
              one_q   <= CMD_SECTOR_ERASE;
              win_q   <= CNT_W'(LOAD_WINDOW_CYC);
              state_q <= S_CMD;
            end else if (!win_left) begin
              WINDOW_OPEN <= 1'b0;
              have_prev_q <= 1'b0;
              to_seen_q   <= 1'b0;
              state_q     <= S_POLL;
            end
            if (one_q == CMD_SUSPEND && kind_q == K_ONE) begin
              state_q <= state_q;
            end
          end
          // Status reads go to the selected sector; preprogram is the
          // device's business and needs nothing from here.
          S_POLL: begin
            WINDOW_OPEN <= 1'b0;
            ph_q <= ph_q + 2'd1;
            unique case (ph_q)
              2'd0: begin
                FL_ADDR <= sect_q;
                FL_CE_N <= 1'b0;
                FL_OE_N <= 1'b0;
              end
              2'd1: ;
              2'd2: begin
                FL_CE_N <= 1'b1;
                FL_OE_N <= 1'b1;
              end
              default: begin
                ph_q        <= '0;
                have_prev_q <= 1'b1;
                prev_t1_q   <= dq_s2_q[BIT_TOGGLE1];
                if (have_prev_q && dq_s2_q[BIT_POLL] && rdy_s2_q &&
                    dq_s2_q[BIT_TOGGLE1] == prev_t1_q) begin
                  if (one_q == CMD_SUSPEND && kind_q == K_ONE) begin
                    SUSPENDED <= 1'b1;
                    BUSY      <= 1'b0;
                    state_q   <= S_SUSP;
                  end else begin
                    DONE    <= 1'b1;
                    BUSY    <= 1'b0;
                    state_q <= S_IDLE;
                  end
                end else if (have_prev_q && dq_s2_q[BIT_TIMEOUT]) begin
                  // Toggle may stop just as the timeout flag rises, so
                  // check once more before declaring failure.
                  if (to_seen_q) begin
                    FAILED  <= 1'b1;
                    kind_q  <= K_ONE;
                    one_q   <= CMD_RESET;
                    state_q <= S_CMD;
                  end
                  to_seen_q <= 1'b1;
                end else if (SUSPEND && !(kind_q == K_CHIP)) begin
                  kind_q  <= K_ONE;
                  one_q   <= CMD_SUSPEND;
                  state_q <= S_CMD;
                end
              end
            endcase
          end
          S_SUSP: begin
            if (RESUME) begin
              SUSPENDED <= 1'b0;
              kind_q    <= K_ONE;
              one_q     <= CMD_RESUME;
              state_q   <= S_CMD;
            end
          end
          // Reset pin held low, then released; chip erase must be redone.
          S_HWRST: begin
            ph_q <= ph_q + 2'd1;
            if (ph_q == 2'd3) begin
              FL_RESET_N <= 1'b1;
              BUSY       <= 1'b0;
              FAILED     <= 1'b1;
              ph_q       <= '0;
              state_q    <= S_IDLE;
            end
          end
          default: state_q <= S_IDLE;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ==== logic/fesq_pkg.sv ====
/*
  Package for the flash erase sequencer host controller: command codes,
  unlock cycle defaults, bus widths, status bit positions and timing counts.
  Assumes a 25 MHz controller clock.
*/
package fesq_pkg;
  localparam int unsigned ADDR_W = 21;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned CLK_MHZ = 25;
  // Command codes of the erase family.
  localparam logic [7:0] CMD_SETUP        = 8'h80;
  localparam logic [7:0] CMD_SECTOR_ERASE = 8'h30;
  localparam logic [7:0] CMD_CHIP_ERASE   = 8'h10;
  localparam logic [7:0] CMD_SUSPEND      = 8'hB0;
  localparam logic [7:0] CMD_RESUME       = 8'h30;
  localparam logic [7:0] CMD_RESET        = 8'hF0;
  // Unlock cycle defaults; the values are arbitrary and overridable.
  localparam logic [ADDR_W-1:0] UNLOCK1_ADDR = 21'h00_0555;
  localparam logic [DATA_W-1:0] UNLOCK1_DATA = 8'hAA;
  localparam logic [ADDR_W-1:0] UNLOCK2_ADDR = 21'h00_02AA;
  localparam logic [DATA_W-1:0] UNLOCK2_DATA = 8'h55;
  // Status bit positions on the data bus.
  localparam int unsigned BIT_POLL    = 7;
  localparam int unsigned BIT_TOGGLE1 = 6;
  localparam int unsigned BIT_TIMEOUT = 5;
  localparam int unsigned BIT_ETIMER  = 3;
  localparam int unsigned BIT_TOGGLE2 = 2;
  // Bus cycle phase length and the sector-load window.
  localparam int unsigned PHASE_CYC = 3;
  localparam int unsigned LOAD_WINDOW_US = 50;
  localparam int unsigned LOAD_WINDOW_CYC = LOAD_WINDOW_US * CLK_MHZ;
  localparam int unsigned CNT_W = 12;
endpackage

// ==== testbench/fesq_flash_model.sv ====
/*
  Behavioural parallel flash: erase command decode, sector-load window,
  self-timed erase, suspend and resume, status bits and ready/busy.
  Assumes the bench resolves the pull-up on ready/busy via the rdy output.
*/
`timescale 1ns/1ps
`default_nettype none
module fesq_flash_model
  import fesq_pkg::*;
#(
  parameter int ERASE_NS = 20000
) (
  input  wire logic [fesq_pkg::ADDR_W-1:0] a,
  input  wire logic [fesq_pkg::DATA_W-1:0] di,
  input  wire logic                        di_oe,
  input  wire logic                        ce_n,
  input  wire logic                        we_n,
  input  wire logic                        oe_n,
  input  wire logic                        reset_n,
  input  wire logic                        hang,
  output logic [fesq_pkg::DATA_W-1:0]      dq,
  output logic                             rdy
);
  logic [ADDR_W+DATA_W-1:0] wlog[$];
  bit                       sel[int];
  int                       st = 0, n = 0, rem = 0;
  logic                     chip = 0, q5 = 0, t1 = 0, t2 = 0, s, ok;
  logic [ADDR_W-1:0]        wa;
  logic [DATA_W-1:0]        q = '0;
  realtime                  tw;
  wire                      wr_n = ce_n | we_n;
  wire                      rd_n = ce_n | oe_n;
  assign dq = di_oe ? di : q;
  assign rdy = !(st == 1 || st == 2);
  always @(negedge wr_n) wa = a;
  always @(posedge wr_n) if (reset_n === 1'b1) cmd(wa, di);
  always @(negedge reset_n) begin
    st = 0;
    n = 0;
    q5 = 0;
  end
  task automatic cmd(input logic [ADDR_W-1:0] ad, input logic [7:0] d);
    wlog.push_back({ad, d});
    case (st)
      1: if (d == CMD_SECTOR_ERASE) begin
        sel[int'(ad[20:12])] = 1;
        tw = $realtime;
      end else st = (d == CMD_SUSPEND) ? 3 : 0;
      2: if (d == CMD_SUSPEND && !chip) st = 3;
      else if (d == CMD_RESET && q5) st = 0;
      3: if (d == CMD_RESUME) st = 2;
      default: begin
        ok = (n == 0 || n == 3) ? ad == UNLOCK1_ADDR && d == UNLOCK1_DATA :
             (n == 1 || n == 4) ? ad == UNLOCK2_ADDR && d == UNLOCK2_DATA :
             (n == 2) ? ad == UNLOCK1_ADDR && d == CMD_SETUP :
             d == CMD_SECTOR_ERASE || d == CMD_CHIP_ERASE;
        n = ok ? n + 1 : 0;
        if (n == 6) begin
          n = 0;
          q5 = 0;
          sel.delete();
          sel[int'(ad[20:12])] = 1;
          chip = (d == CMD_CHIP_ERASE);
          st = chip ? 2 : 1;
          tw = $realtime;
          rem = ERASE_NS;
        end
      end
    endcase
  endtask
  // Coarse 100 ns tick keeps the model cheap; window end is late by up to 100 ns.
  always #100 begin
    if (st == 1 && $realtime - tw > 50000) st = 2;
    else if (st == 2) begin
      rem -= 100;
      if (rem <= 0 && hang) q5 = 1;
      else if (rem <= 0) st = 0;
    end
  end
  always @(negedge rd_n) if (reset_n === 1'b1) begin
    s = chip || sel.exists(int'(a[20:12]));
    if (st == 1 || st == 2) t1 = ~t1;
    if (st != 0 && s) t2 = ~t2;
    if (st == 0 || (st == 3 && !s)) q = 8'hFF;
    else if (st == 3) q = {1'b1, t1, 4'h0, t2, 1'b0} | 8'h00;
    else q = {~s, t1, q5, 1'b0, st == 2, t2, 2'b00};
  end
  // A released bus shows the inverse of the last value, never a held copy.
  always @(posedge rd_n) q = ~q;
endmodule
`default_nettype wire

// ==== testbench/fesq_host_props.sv ====
/*
  Concurrent checks on the pins and status ports of the erase sequencer host.
  Assumes it is bound to fesq_host and sees that module's ports only.
*/
`timescale 1ns/1ps
`default_nettype none
module fesq_host_props (
  input wire logic                        REF_CLK,
  input wire logic                        ARST_N,
  input wire logic                        CLK_EN,
  input wire logic                        ABORT,
  input wire logic                        BUSY,
  input wire logic                        DONE,
  input wire logic                        FAILED,
  input wire logic                        SUSPENDED,
  input wire logic                        WINDOW_OPEN,
  input wire logic [fesq_pkg::ADDR_W-1:0] FL_ADDR,
  input wire logic                        FL_DQ_OE,
  input wire logic                        FL_CE_N,
  input wire logic                        FL_WE_N,
  input wire logic                        FL_OE_N,
  input wire logic                        FL_RESET_N
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);
  property p_we_in_ce; !FL_WE_N |-> !FL_CE_N; endproperty
  a_we_in_ce: assert property (p_we_in_ce) else $error("write strobe outside select");
  property p_we_one; $fell(FL_WE_N) |=> FL_WE_N; endproperty
  a_we_one: assert property (p_we_one) else $error("write strobe too long");
  property p_addr_hold; !FL_CE_N && !$past(FL_CE_N) |-> $stable(FL_ADDR); endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved in cycle");
  property p_drive_we; !FL_WE_N |-> FL_DQ_OE; endproperty
  a_drive_we: assert property (p_drive_we) else $error("write without data drive");
  property p_no_clash; !FL_OE_N |-> !FL_DQ_OE && FL_WE_N; endproperty
  a_no_clash: assert property (p_no_clash) else $error("read overlaps write");
  property p_abort; ABORT && CLK_EN |-> ##[1:2] !FL_RESET_N; endproperty
  a_abort: assert property (p_abort) else $error("abort gave no reset pulse");
  property p_rst_len; $fell(FL_RESET_N) |-> !FL_RESET_N [*4] ##1 FL_RESET_N; endproperty
  a_rst_len: assert property (p_rst_len) else $error("reset pulse length wrong");
  property p_done_pulse; DONE |=> !DONE && !FAILED; endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done not a pulse");
  property p_window; WINDOW_OPEN |-> BUSY && !SUSPENDED; endproperty
  a_window: assert property (p_window) else $error("window state inconsistent");
  c_done: cover property (DONE);
  c_susp: cover property ($rose(SUSPENDED));
  c_fail: cover property ($rose(FAILED));
endmodule
bind fesq_host fesq_host_props u_props (.REF_CLK, .ARST_N, .CLK_EN, .ABORT,
  .BUSY, .DONE, .FAILED, .SUSPENDED, .WINDOW_OPEN, .FL_ADDR, .FL_DQ_OE,
  .FL_CE_N, .FL_WE_N, .FL_OE_N, .FL_RESET_N);
`default_nettype wire

// ==== testbench/tb_top.sv ====
/*
  Self-checking bench for the erase sequencer host against a flash model.
  Assumes the design package and the behavioural flash model are compiled.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import fesq_pkg::*;
  logic              clk = 0, arst_n = 0, hang = 0, f_d = 0, cen = 1;
  logic [5:0]        rq = '0;
  logic [ADDR_W-1:0] sa = '0, fa;
  logic [DATA_W-1:0] fdo, fdi;
  logic              busy, done, failed, susp, win, foe, ce_n, we_n, oe_n;
  logic              frst_n, rdy;
  logic [1:0]        exp_q[$];
  int                n_fail = 0, n_checks = 0, nw = 0;
  always #20 clk = ~clk;
  fesq_host dut (.REF_CLK(clk), .ARST_N(arst_n), .CLK_EN(cen),
    .START_CHIP(rq[0]), .START_SECTOR(rq[1]), .ADD_SECTOR(rq[2]),
    .SECTOR_ADDR(sa), .SUSPEND(rq[3]), .RESUME(rq[4]), .ABORT(rq[5]),
    .BUSY(busy), .DONE(done), .FAILED(failed), .SUSPENDED(susp),
    .WINDOW_OPEN(win), .FL_ADDR(fa), .FL_DQ_O(fdo), .FL_DQ_OE(foe),
    .FL_DQ_I(fdi), .FL_CE_N(ce_n), .FL_WE_N(we_n), .FL_OE_N(oe_n),
    .FL_RESET_N(frst_n), .FL_RDY_I(rdy));
  fesq_flash_model flash (.a(fa), .di(fdo), .di_oe(foe), .ce_n(ce_n),
    .we_n(we_n), .oe_n(oe_n), .reset_n(frst_n), .hang(hang), .dq(fdi),
    .rdy(rdy));
  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic req(input int k, input int hold);
    @(negedge clk);
    rq = 6'(1 << k);
    repeat (hold) @(negedge clk);
    rq = '0;
  endtask
  task automatic wait_for(input int k, input int lim);
    repeat (lim) begin
      @(negedge clk);
      if ((k == 0 && win) || (k == 1 && susp) || (k == 2 && !busy) ||
          (k == 3 && flash.st == 2) || (k == 4 && failed)) return;
    end
    chk("wait bound", k, 32'hFFFF_FFFF);
    results();
  endtask
  task automatic seq_chk(input logic [7:0] c, input logic any_a);
    logic [28:0] e[6];
    int b;
    b = flash.wlog.size() - 6;
    e = '{{UNLOCK1_ADDR, UNLOCK1_DATA}, {UNLOCK2_ADDR, UNLOCK2_DATA},
      {UNLOCK1_ADDR, CMD_SETUP}, {UNLOCK1_ADDR, UNLOCK1_DATA},
      {UNLOCK2_ADDR, UNLOCK2_DATA}, {sa, c}};
    if (any_a) e[5][28:8] = flash.wlog[b + 5][28:8];
    for (int i = 0; i < 6; i++) chk("write cycle", flash.wlog[b + i], e[i]);
  endtask
  // The outcome watcher pairs each completion with the oldest note.
  always @(negedge clk) begin
    f_d <= failed;
    if (done === 1'b1 || (failed === 1'b1 && !f_d))
      chk("outcome", {done, failed}, exp_q.size() ? exp_q.pop_front() : 2'b11);
  end
  initial begin
    void'($urandom(28656));
    repeat (4) @(negedge clk);
    arst_n = 1;
    // A start request while the clock enable is low must be lost.
    cen = 0;
    nw = flash.wlog.size();
    req(1, 1);
    repeat (3) @(negedge clk);
    chk("frozen busy", busy, 0);
    chk("frozen writes", flash.wlog.size(), nw);
    cen = 1;
    sa = ADDR_W'($urandom) & 21'h1F_F000;
    exp_q.push_back(2'b10);
    req(1, 1);
    wait_for(0, 100);
    seq_chk(CMD_SECTOR_ERASE, 0);
    sa = sa ^ 21'h00_1000;
    req(2, 1);
    wait_for(2, 4000);
    chk("added sector", flash.wlog[$], {sa, CMD_SECTOR_ERASE});
    chk("sector count", flash.sel.size(), 2);
    exp_q.push_back(2'b10);
    req(0, 1);
    wait_for(2, 4000);
    seq_chk(CMD_CHIP_ERASE, 1);
    for (int m = 0; m < 2; m++) begin
      sa = ADDR_W'($urandom);
      exp_q.push_back(2'b10);
      req(1, 1);
      wait_for(m ? 3 : 0, 2000);
      req(3, 5);
      wait_for(1, 1000);
      chk("suspended", flash.st, 3);
      chk("ready pin", rdy, 1);
      chk("suspend flag", susp, 1);
      // Busy stays low until the resume write is out, so wait for it.
      req(4, 1);
      wait_for(3, 200);
      chk("resume code", flash.wlog[$][7:0], CMD_RESUME);
      wait_for(2, 4000);
    end
    hang = 1;
    exp_q.push_back(2'b01);
    req(1, 1);
    wait_for(4, 4000);
    // The stall is kept until the reset write, so only that write ends it.
    wait_for(2, 200);
    chk("reset code", flash.wlog[$][7:0], CMD_RESET);
    chk("array mode", flash.st, 0);
    hang = 0;
    exp_q.push_back(2'b01);
    req(0, 1);
    wait_for(3, 200);
    req(5, 1);
    wait_for(4, 100);
    wait_for(2, 100);
    chk("aborted", flash.st, 0);
    chk("notes left", exp_q.size(), 0);
    results();
  end
endmodule
`default_nettype wire
